// ===== src/srac_pkg.sv
// Constants shared by the serial register access front end.
// Assumes a 50 MHz core clock and a host SPI master running mode 3.
// What this block does
// - Standby keeps registers and forces the not-ready flag high.
// - Standby indication drives the shared output pin when enabled.
// - Checks may stay on in standby; oscillator kept if checks need it.
// - Separate bits keep outputs, switch, open-wire, bias, excitation on in standby.
// - Internal reference kept in standby only when both its bits are set.
// - Standby ends by writing another mode into the mode field or by a soft reset.
// - Mode 3 link: sample DIN on SCLK rise, drive DOUT on fall.
// - After reset the interface waits for a command byte first.
// - Command byte: bit7 write enable (0), bit6 read/write, bits 5:0 address.
// - Command bit7 received as 1 makes the rest of the byte ignored.
// - Chip select high in 4-wire use aborts and returns to command wait.
// - After the data phase the interface waits for a new command.
// - Data phase is 8, 16, 24 or 32 bits, set by register and options.
// - Identification register is read-only.
// - 64 consecutive ones on DIN reset the whole device to defaults.
// - Access too soon after reset is ignored and sets a W1C error flag.
// - Power-on flag sets at reset and clears when status is read.
// - Full reset happens at power-up.
// - Bipolar bit 1: offset binary, zero gives 0x800000.
// - Bipolar bit 0: straight binary, negative input clamps to 0x000000.
// - Bipolar setting also steers calibration and threshold interpretation.
// - Status append bit adds the status byte after each result read.
package srac_pkg;
	localparam int          CLK_MHZ         = 50;
	localparam int          RESET_DELAY_NS  = 2000;
	localparam int          RESET_DELAY_CYC = (RESET_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int          SW_RESET_ONES   = 64;
	// Register addresses
	localparam logic [5:0]  ADDR_COMMAND    = 6'h00;
	localparam logic [5:0]  ADDR_STATUS     = 6'h00;
	localparam logic [5:0]  ADDR_ADC_CTRL   = 6'h01;
	localparam logic [5:0]  ADDR_DATA       = 6'h02;
	localparam logic [5:0]  ADDR_ID         = 6'h05;
	localparam logic [5:0]  ADDR_ERROR      = 6'h06;
	localparam logic [5:0]  ADDR_MISC       = 6'h07;
	// Reset values
	localparam logic [15:0] ADC_CTRL_RST    = 16'h4000;
	localparam logic [15:0] MISC_RST        = 16'h0000;
	localparam logic [7:0]  ID_VALUE        = 8'h5a;  // Arbitrary value
	// Command byte fields
	localparam int          CMD_WEN_BIT     = 7;
	localparam int          CMD_RD_BIT      = 6;
	// Control register fields
	localparam int          CTL_BIPOLAR     = 14;
	localparam int          CTL_APPEND      = 10;
	localparam int          CTL_CS_EN       = 9;
	localparam int          CTL_MODE_LSB    = 2;
	localparam logic [3:0]  MODE_STANDBY    = 4'h2;
	// Status register fields
	localparam int          ST_NOT_READY    = 7;
	localparam int          ST_ANY_ERR      = 6;
	localparam int          ST_POR          = 4;
	// Misc register fields
	localparam int          MISC_CHECKS     = 0;
	localparam int          MISC_OUTPUTS    = 1;
	localparam int          MISC_SWITCH     = 2;
	localparam int          MISC_OPEN_WIRE  = 3;
	localparam int          MISC_BIAS       = 4;
	localparam int          MISC_EXC        = 5;
	localparam int          MISC_REF_HOLD   = 6;
	localparam int          MISC_INT_REF    = 7;
	localparam int          MISC_PIN_OE     = 8;
	localparam int          ERR_IGNORED     = 0;
	localparam logic [23:0] CODE_MID        = 24'h800000;
	localparam logic [23:0] CODE_ZERO       = 24'h000000;

	typedef enum logic [1:0] {
		SRAC_CMD  = 2'b00,
		SRAC_SKIP = 2'b01,
		SRAC_DATA = 2'b10
	} srac_state_t;
endpackage

// ===== src/srac_ctrl.sv
// Serial register access front end: mode 3 slave, registers, standby and coding.
// Assumes SCLK, chip select and DIN come from pins outside the core clock domain
// and that SCLK is slow enough (8 core clocks per period or more) to be sampled.
`timescale 1ns/100ps
module srac_ctrl (
	input  wire logic        i_clk,             // Core clock, 50 MHz
	input  wire logic        i_rst,             // Async power-on reset, active high
	input  wire logic        i_sclk,            // Serial clock pin
	input  wire logic        i_cs_n,            // Chip select pin, active low
	input  wire logic        i_din,             // Serial data in pin
	input  wire logic [23:0] i_raw_result,      // Filter result, two's complement
	input  wire logic        i_raw_valid,       // Result strobe, one cycle
	input  wire logic [3:0]  i_channel,         // Channel of the latest result
	input  wire logic        i_duty_standby,    // Standby phase of duty cycling
	input  wire logic        i_osc_checks_en,   // An enabled check needs the oscillator
	output logic             o_dout,            // Serial data out
	output logic             o_dout_oe,         // Data out drive enable
	output logic             o_soft_reset,      // Pulse: reset filter and modulator
	output logic             o_standby,         // Standby in force
	output logic             o_standby_pin,     // Standby shown on shared output pin
	output logic             o_keep_checks,     // Checks powered in standby
	output logic             o_keep_osc,        // Oscillator held running
	output logic             o_keep_outputs,    // General outputs powered
	output logic             o_keep_switch,     // Low-side switch powered
	output logic             o_keep_open_wire,  // Open-wire currents powered
	output logic             o_keep_bias,       // Bias generator powered
	output logic             o_keep_excitation, // Excitation currents powered
	output logic             o_keep_int_ref,    // Internal reference powered
	output logic             o_bipolar,         // Coding for calibration and thresholds
	output logic [3:0]       o_mode             // Operating mode field
);
	logic              sclk_s1, sclk_s2, sclk_s3;
	logic              cs_s1, cs_s2, cs_s3;
	logic              din_s1, din_s2;
	logic              sclk_rise, sclk_fall, cs_rise, cs_active;
	srac_pkg::srac_state_t state_reg;
	logic [5:0]        bit_cnt_reg;
	logic [5:0]        len_reg;
	logic              rd_reg;
	logic [5:0]        addr_reg;
	logic [31:0]       rx_reg;
	logic [31:0]       tx_reg;
	logic [6:0]        ones_reg;
	logic              sw_rst_reg;
	logic [7:0]        delay_reg;
	logic [15:0]       adc_ctrl_reg;
	logic [15:0]       misc_reg;
	logic [23:0]       data_reg;
	logic              data_rdy_reg;
	logic              por_reg;
	logic              ign_err_reg;
	logic [7:0]        status_w;
	logic              standby_w;
	logic              cmd_done, data_done, busy_w;
	logic [7:0]        cmd_w;
	logic [31:0]       rx_next;

	// Bits carried by the data phase of each register
	function automatic logic [5:0] reg_len(input logic [5:0] a, input logic app);
		case (a)
			srac_pkg::ADDR_ADC_CTRL: reg_len = 6'd16;
			srac_pkg::ADDR_DATA:     reg_len = app ? 6'd32 : 6'd24;
			srac_pkg::ADDR_MISC:     reg_len = 6'd16;
			default:                 reg_len = 6'd8;
		endcase
	endfunction

	// Pin sampling; stage one feeds only stage two
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			{sclk_s1, sclk_s2, sclk_s3} <= 3'b111;
			{cs_s1, cs_s2, cs_s3}       <= 3'b111;
			{din_s1, din_s2}            <= 2'b00;
		end else begin
			{sclk_s1, sclk_s2, sclk_s3} <= {i_sclk, sclk_s1, sclk_s2};
			{cs_s1, cs_s2, cs_s3}       <= {i_cs_n, cs_s1, cs_s2};
			{din_s1, din_s2}            <= {i_din, din_s1};
		end
	end

	// Without chip select enabled the link runs 3-wire, select treated as low
	assign cs_active = ~adc_ctrl_reg[srac_pkg::CTL_CS_EN] | ~cs_s2;
	assign cs_rise   = adc_ctrl_reg[srac_pkg::CTL_CS_EN] & cs_s2 & ~cs_s3;
	assign sclk_rise = sclk_s2 & ~sclk_s3 & cs_active;
	assign sclk_fall = ~sclk_s2 & sclk_s3 & cs_active;
	assign busy_w    = delay_reg != 8'h00;
	assign rx_next   = {rx_reg[30:0], din_s2};
	assign cmd_w     = rx_next[7:0];
	// Both ends are decoded from the rise itself, so data lands without an extra clock
	assign cmd_done  = sclk_rise & ~busy_w & state_reg == srac_pkg::SRAC_CMD
		& bit_cnt_reg == 6'd7;
	assign data_done = sclk_rise & ~busy_w & state_reg == srac_pkg::SRAC_DATA
		& bit_cnt_reg == len_reg - 6'd1;
	assign standby_w = adc_ctrl_reg[srac_pkg::CTL_MODE_LSB +: 4] == srac_pkg::MODE_STANDBY
		| i_duty_standby;

	always_comb begin
		status_w                         = {4'h0, i_channel};
		status_w[srac_pkg::ST_NOT_READY] = ~data_rdy_reg | standby_w;
		status_w[srac_pkg::ST_ANY_ERR]   = ign_err_reg;
		status_w[srac_pkg::ST_POR]       = por_reg;
	end

	// 64 ones in a row restart everything; counted before any other decode
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ones_reg   <= 7'd0;
			sw_rst_reg <= 1'b0;
		end else begin
			sw_rst_reg <= 1'b0;
			if (sclk_rise) begin
				if (!din_s2) begin
					ones_reg <= 7'd0;
				end else if (ones_reg == 7'(srac_pkg::SW_RESET_ONES - 1)) begin
					ones_reg   <= 7'd0;
					sw_rst_reg <= 1'b1;
				end else begin
					ones_reg <= ones_reg + 7'd1;
				end
			end
		end
	end

	// Quiet time after any reset; the link is not served until it runs out
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			delay_reg <= 8'(srac_pkg::RESET_DELAY_CYC);
		end else if (sw_rst_reg) begin
			delay_reg <= 8'(srac_pkg::RESET_DELAY_CYC);
		end else if (busy_w) begin
			delay_reg <= delay_reg - 8'h01;
		end
	end

	// Link sequencer
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg   <= srac_pkg::SRAC_CMD;
			bit_cnt_reg <= 6'd0;
			len_reg     <= 6'd8;
			rd_reg      <= 1'b0;
			addr_reg    <= 6'h00;
			rx_reg      <= 32'h0;
		end else if (sw_rst_reg || cs_rise) begin
			state_reg   <= srac_pkg::SRAC_CMD;
			bit_cnt_reg <= 6'd0;
			rx_reg      <= 32'h0;
		end else if (sclk_rise && !busy_w) begin
			rx_reg      <= rx_next;
			bit_cnt_reg <= bit_cnt_reg + 6'd1;
			case (state_reg)
				srac_pkg::SRAC_CMD: begin
					if (bit_cnt_reg == 6'd0 && din_s2) begin
						// A set first bit marks a frame we must not decode
						state_reg <= srac_pkg::SRAC_SKIP;
					end else if (cmd_done) begin
						state_reg   <= srac_pkg::SRAC_DATA;
						bit_cnt_reg <= 6'd0;
						rd_reg      <= cmd_w[srac_pkg::CMD_RD_BIT];
						addr_reg    <= cmd_w[5:0];
						len_reg     <= reg_len(cmd_w[5:0],
							adc_ctrl_reg[srac_pkg::CTL_APPEND]);
					end
				end
				srac_pkg::SRAC_SKIP: begin
					rx_reg <= rx_reg;
					if (bit_cnt_reg == 6'd7) begin
						state_reg   <= srac_pkg::SRAC_CMD;
						bit_cnt_reg <= 6'd0;
					end
				end
				srac_pkg::SRAC_DATA: begin
					if (data_done) begin
						state_reg   <= srac_pkg::SRAC_CMD;
						bit_cnt_reg <= 6'd0;
					end
				end
				default: begin
					state_reg   <= srac_pkg::SRAC_CMD;
					bit_cnt_reg <= 6'd0;
				end
			endcase
		end
	end

	// Read data: loaded at the end of the command, shifted out on falling edges
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tx_reg    <= 32'h0;
			o_dout    <= 1'b1;
			o_dout_oe <= 1'b0;
		end else begin
			o_dout_oe <= cs_active;
			if (sw_rst_reg || cs_rise) begin
				tx_reg <= 32'h0;
				o_dout <= 1'b1;
			end else if (cmd_done && cmd_w[srac_pkg::CMD_RD_BIT]) begin
				case (cmd_w[5:0])
					srac_pkg::ADDR_STATUS:   tx_reg <= {status_w, 24'h0};
					srac_pkg::ADDR_ADC_CTRL: tx_reg <= {adc_ctrl_reg, 16'h0};
					srac_pkg::ADDR_DATA:     tx_reg <= {data_reg, status_w};
					srac_pkg::ADDR_ID:       tx_reg <= {srac_pkg::ID_VALUE, 24'h0};
					srac_pkg::ADDR_ERROR:    tx_reg <= {7'h0, ign_err_reg, 24'h0};
					srac_pkg::ADDR_MISC:     tx_reg <= {misc_reg, 16'h0};
					default:                 tx_reg <= 32'h0;
				endcase
			end else if (sclk_fall && state_reg == srac_pkg::SRAC_DATA && rd_reg) begin
				o_dout <= tx_reg[31];
				tx_reg <= {tx_reg[30:0], 1'b0};
			end else if (state_reg != srac_pkg::SRAC_DATA) begin
				// Last bit is only held to the final rise; hosts must sample there
				o_dout <= 1'b1;
			end
		end
	end

	// Register writes; the identification register has no write path
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			adc_ctrl_reg <= srac_pkg::ADC_CTRL_RST;
			misc_reg     <= srac_pkg::MISC_RST;
		end else if (sw_rst_reg) begin
			adc_ctrl_reg <= srac_pkg::ADC_CTRL_RST;
			misc_reg     <= srac_pkg::MISC_RST;
		end else if (data_done && !rd_reg) begin
			case (addr_reg)
				srac_pkg::ADDR_ADC_CTRL: adc_ctrl_reg <= rx_next[15:0];
				srac_pkg::ADDR_MISC:     misc_reg     <= rx_next[15:0];
				default:                 misc_reg     <= misc_reg;
			endcase
		end
	end

	// Result coding and flags; a setting event wins over a same-cycle clear
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			data_reg     <= srac_pkg::CODE_ZERO;
			data_rdy_reg <= 1'b0;
			por_reg      <= 1'b1;
			ign_err_reg  <= 1'b0;
		end else if (sw_rst_reg) begin
			data_reg     <= srac_pkg::CODE_ZERO;
			data_rdy_reg <= 1'b0;
			por_reg      <= 1'b1;
			ign_err_reg  <= 1'b0;
		end else begin
			if (i_raw_valid) begin
				data_rdy_reg <= 1'b1;
				if (adc_ctrl_reg[srac_pkg::CTL_BIPOLAR]) begin
					data_reg <= i_raw_result ^ srac_pkg::CODE_MID;
				end else if (i_raw_result[23]) begin
					data_reg <= srac_pkg::CODE_ZERO;
				end else begin
					data_reg <= {i_raw_result[22:0], 1'b0};
				end
			end else if (cmd_done && cmd_w[srac_pkg::CMD_RD_BIT]
				&& cmd_w[5:0] == srac_pkg::ADDR_DATA) begin
				data_rdy_reg <= 1'b0;
			end
			if (cmd_done && cmd_w[srac_pkg::CMD_RD_BIT]
				&& cmd_w[5:0] == srac_pkg::ADDR_STATUS) begin
				por_reg <= 1'b0;
			end
			if (sclk_rise && busy_w) begin
				ign_err_reg <= 1'b1;
			end else if (data_done && !rd_reg && addr_reg == srac_pkg::ADDR_ERROR
				&& rx_next[srac_pkg::ERR_IGNORED]) begin
				ign_err_reg <= 1'b0;
			end
		end
	end

	// Standby power steering, all registered
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_soft_reset      <= 1'b0;
			o_standby         <= 1'b0;
			o_standby_pin     <= 1'b0;
			o_keep_checks     <= 1'b0;
			o_keep_osc        <= 1'b0;
			o_keep_outputs    <= 1'b0;
			o_keep_switch     <= 1'b0;
			o_keep_open_wire  <= 1'b0;
			o_keep_bias       <= 1'b0;
			o_keep_excitation <= 1'b0;
			o_keep_int_ref    <= 1'b0;
			o_bipolar         <= 1'b1;
			o_mode            <= 4'h0;
		end else begin
			o_soft_reset      <= sw_rst_reg;
			o_standby         <= standby_w;
			o_standby_pin     <= standby_w & misc_reg[srac_pkg::MISC_PIN_OE];
			o_keep_checks     <= standby_w & misc_reg[srac_pkg::MISC_CHECKS];
			o_keep_osc        <= standby_w & misc_reg[srac_pkg::MISC_CHECKS]
				& i_osc_checks_en;
			o_keep_outputs    <= standby_w & misc_reg[srac_pkg::MISC_OUTPUTS];
			o_keep_switch     <= standby_w & misc_reg[srac_pkg::MISC_SWITCH];
			o_keep_open_wire  <= standby_w & misc_reg[srac_pkg::MISC_OPEN_WIRE];
			o_keep_bias       <= standby_w & misc_reg[srac_pkg::MISC_BIAS];
			o_keep_excitation <= standby_w & misc_reg[srac_pkg::MISC_EXC];
			o_keep_int_ref    <= standby_w & misc_reg[srac_pkg::MISC_REF_HOLD]
				& misc_reg[srac_pkg::MISC_INT_REF];
			o_bipolar         <= adc_ctrl_reg[srac_pkg::CTL_BIPOLAR];
			o_mode            <= adc_ctrl_reg[srac_pkg::CTL_MODE_LSB +: 4];
		end
	end
endmodule // srac_ctrl

// ===== tb/srac_host.sv
// Host SPI master model driving the serial register access front end.
// Assumes mode 3 and a device that drives DOUT a few core clocks after each fall.
`timescale 1ns/100ps
module srac_host (
	output logic      o_sclk,    // Serial clock, idles high
	output logic      o_cs_n,    // Chip select, active low
	output logic      o_din,     // Data to the device
	input  wire logic i_dout,    // Data from the device
	input  wire logic i_dout_oe  // Device drives DOUT
);
	initial begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_din  = 1'b0;
	end
	// Sends the low n bits of w MSB first and returns what came back.
	// DOUT is read at the rising edge: the last bit is dropped soon after it.
	task automatic xfer(input int n, input logic [63:0] w, output logic [63:0] r);
		r = '0;
		o_cs_n = 1'b0;
		#80;
		for (int i = n - 1; i >= 0; i--) begin
			o_sclk = 1'b0;
			o_din  = w[i];
			#80;
			r[i] = (i_dout_oe === 1'b1) ? i_dout : 1'bx;
			o_sclk = 1'b1;
			#80;
		end
		o_din = ~o_din;
		#80;
		o_cs_n = 1'b1;
		#160;
	endtask
endmodule // srac_host

// ===== tb/srac_ctrl_monitor.sv
// Checker for the serial register access front end, bound to its top module.
// Assumes one core clock domain with an active-high reset.
`timescale 1ns/100ps
module srac_ctrl_monitor (
	input wire logic        i_clk, i_rst, i_sclk, i_cs_n, i_din, // Clock, reset, link
	input wire logic [23:0] i_raw_result,                        // Filter result
	input wire logic        i_raw_valid, i_duty_standby,          // Result strobe, duty
	input wire logic [3:0]  i_channel,                           // Result channel
	input wire logic        i_osc_checks_en, o_dout, o_dout_oe,   // Oscillator need, DOUT
	input wire logic        o_soft_reset, o_standby, o_standby_pin, // Reset, standby
	input wire logic        o_keep_checks, o_keep_osc, o_keep_outputs, // Keep bits
	input wire logic        o_keep_switch, o_keep_open_wire, o_keep_bias, // Keep bits
	input wire logic        o_keep_excitation, o_keep_int_ref, o_bipolar, // Keep, coding
	input wire logic [3:0]  o_mode                               // Operating mode
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	chk_pin_follows_standby: assert property (o_standby_pin |-> o_standby)
		else $error("standby pin high outside standby");
	chk_osc_needs_checks: assert property (o_keep_osc |-> o_keep_checks && $past(i_osc_checks_en))
		else $error("oscillator kept without its cause");
	chk_keeps_in_standby: assert property ((o_keep_outputs || o_keep_switch || o_keep_open_wire
		|| o_keep_bias || o_keep_excitation) |-> o_standby)
		else $error("function kept powered outside standby");
	chk_int_ref_hold: assert property (o_keep_int_ref |-> o_standby)
		else $error("internal reference kept outside standby");
	chk_standby_mode: assert property ((o_mode == srac_pkg::MODE_STANDBY) [*2] |-> o_standby)
		else $error("standby mode without standby");
	chk_soft_pulse_one: assert property (o_soft_reset |=> !o_soft_reset)
		else $error("soft reset pulse longer than one clock");
	chk_soft_defaults: assert property (o_soft_reset |-> ##[0:3] (o_bipolar && o_mode == 4'h0))
		else $error("defaults not restored after soft reset");
	chk_power_defaults: assert property ($fell(i_rst) |-> o_bipolar && o_mode == 4'h0 && !o_standby)
		else $error("wrong state after power-on reset");
endmodule // srac_ctrl_monitor
bind srac_ctrl srac_ctrl_monitor mon (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(i_sclk),
	.i_cs_n(i_cs_n), .i_din(i_din), .i_raw_result(i_raw_result), .i_raw_valid(i_raw_valid),
	.i_channel(i_channel), .i_duty_standby(i_duty_standby), .i_osc_checks_en(i_osc_checks_en),
	.o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_soft_reset(o_soft_reset), .o_standby(o_standby),
	.o_standby_pin(o_standby_pin), .o_keep_checks(o_keep_checks), .o_keep_osc(o_keep_osc),
	.o_keep_outputs(o_keep_outputs), .o_keep_switch(o_keep_switch),
	.o_keep_open_wire(o_keep_open_wire), .o_keep_bias(o_keep_bias),
	.o_keep_excitation(o_keep_excitation), .o_keep_int_ref(o_keep_int_ref),
	.o_bipolar(o_bipolar), .o_mode(o_mode));

// ===== tb/testbench.sv
// Self-checking bench: register traffic over the serial link through the host model.
// Assumes the core clock at 50 MHz and a free-phase 160 ns serial clock.
`timescale 1ns/100ps
module testbench;
	logic        i_clk, i_rst, sclk, cs_n, din, i_raw_valid, i_duty_standby, i_osc_checks_en;
	logic [23:0] i_raw_result;
	logic [3:0]  i_channel, o_mode;
	logic        o_dout, o_dout_oe, o_soft_reset, o_standby, o_standby_pin, o_keep_checks;
	logic        o_keep_osc, o_keep_outputs, o_keep_switch, o_keep_open_wire, o_keep_bias;
	logic        o_keep_excitation, o_keep_int_ref, o_bipolar;
	logic [63:0] rv;
	int          err_total = 0;
	int          samples_checked = 0;
	int          sr_seen = 0;

	srac_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(o_dout),
		.i_dout_oe(o_dout_oe));
	srac_ctrl uut (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
		.i_raw_result(i_raw_result), .i_raw_valid(i_raw_valid), .i_channel(i_channel),
		.i_duty_standby(i_duty_standby), .i_osc_checks_en(i_osc_checks_en), .o_dout(o_dout),
		.o_dout_oe(o_dout_oe), .o_soft_reset(o_soft_reset), .o_standby(o_standby),
		.o_standby_pin(o_standby_pin), .o_keep_checks(o_keep_checks), .o_keep_osc(o_keep_osc),
		.o_keep_outputs(o_keep_outputs), .o_keep_switch(o_keep_switch),
		.o_keep_open_wire(o_keep_open_wire), .o_keep_bias(o_keep_bias),
		.o_keep_excitation(o_keep_excitation), .o_keep_int_ref(o_keep_int_ref),
		.o_bipolar(o_bipolar), .o_mode(o_mode));

	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	always @(posedge i_clk) if (o_soft_reset === 1'b1) sr_seen <= sr_seen + 1;

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %b", $time, m, got);
		end
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic wr(input logic [7:0] c, input int n, input logic [31:0] d);
		host.xfer(n + 8, (64'(c) << n) | 64'(d), rv);
	endtask
	task automatic rdc(input logic [7:0] c, input int n, input logic [31:0] e, input string m);
		host.xfer(n + 8, 64'(c) << n, rv);
		chk_val(32'(rv & ((64'h1 << n) - 64'h1)), e, m);
	endtask
	task automatic pulse(input logic [23:0] r);
		@(negedge i_clk);
		i_raw_result = r;
		i_raw_valid  = 1'b1;
		@(negedge i_clk);
		i_raw_valid  = 1'b0;
	endtask
	task automatic tend(input string s);
		$display("test %s ended, mismatches so far %0d", s, err_total);
	endtask

	initial begin
		#1000000;
		err_total++;
		$display("BAD %0t run timed out", $time);
		close_out();
	end

	initial begin
		i_rst = 1'b1;
		i_raw_result = '0;
		i_raw_valid = 1'b0;
		i_channel = 4'h0;
		i_duty_standby = 1'b0;
		i_osc_checks_en = 1'b1;
		wait_clk(20);
		i_rst = 1'b0;
		wait_clk(110);
		rdc(8'h40, 8, 32'h90, "status after power-up");
		rdc(8'h40, 8, 32'h80, "status after read");
		rdc(8'h45, 8, 32'(srac_pkg::ID_VALUE), "id");
		wr(8'h05, 8, 32'hff);
		rdc(8'h45, 8, 32'(srac_pkg::ID_VALUE), "id after write");
		rdc(8'h41, 16, 32'(srac_pkg::ADC_CTRL_RST), "control default");
		tend("access");
		wr(8'h07, 16, 32'h01ff);
		chk_pin(o_keep_outputs, 1'b0, "keep outside standby");
		wr(8'h01, 16, 32'h4008);
		wait_clk(3);
		chk_val(32'({o_standby, o_standby_pin, o_keep_checks, o_keep_osc, o_keep_outputs,
			o_keep_switch, o_keep_open_wire, o_keep_bias, o_keep_excitation, o_keep_int_ref}),
			32'h3ff, "standby keeps");
		chk_val(32'(o_mode), 32'(srac_pkg::MODE_STANDBY), "mode field");
		i_osc_checks_en = 1'b0;
		wr(8'h07, 16, 32'h017f);
		chk_pin(o_keep_osc, 1'b0, "oscillator not needed");
		chk_pin(o_keep_int_ref, 1'b0, "reference bit clear");
		rdc(8'h40, 8, 32'h80, "status in standby");
		rdc(8'h47, 16, 32'h017f, "misc kept");
		wr(8'h01, 16, 32'h0000);
		wait_clk(3);
		chk_pin(o_standby, 1'b0, "standby left");
		chk_pin(o_bipolar, 1'b0, "unipolar set");
		i_duty_standby = 1'b1;
		wait_clk(3);
		chk_pin(o_standby, 1'b1, "duty standby");
		i_duty_standby = 1'b0;
		tend("standby");
		pulse(24'h000010);
		rdc(8'h42, 24, 32'h000020, "unipolar code");
		pulse(24'hfffff0);
		rdc(8'h42, 24, 32'(srac_pkg::CODE_ZERO), "negative clamp");
		wr(8'h01, 16, 32'h4000);
		pulse(24'h000000);
		rdc(8'h42, 24, 32'(srac_pkg::CODE_MID), "offset zero");
		i_channel = 4'h3;
		wr(8'h01, 16, 32'h4400);
		pulse(24'h000005);
		host.xfer(40, 64'h42 << 32, rv);
		i_channel = 4'h0;
		chk_val(rv[31:0] & 32'hffffff7f, 32'h80000503, "status appended");
		tend("coding");
		host.xfer(8, 64'h87, rv);
		rdc(8'h47, 16, 32'h017f, "write enable set");
		wr(8'h01, 16, 32'h4200);
		host.xfer(16, 64'h07ff, rv);
		rdc(8'h47, 16, 32'h017f, "abort keeps misc");
		tend("framing");
		host.xfer(64, '1, rv);
		host.xfer(8, 64'h46, rv);
		wait_clk(110);
		chk_val(32'(sr_seen), 32'h1, "soft reset pulse");
		chk_pin(o_bipolar, 1'b1, "bipolar restored");
		rdc(8'h47, 16, 32'(srac_pkg::MISC_RST), "misc restored");
		rdc(8'h46, 8, 32'h01, "ignored access flag");
		rdc(8'h40, 8, 32'hd0, "status after soft reset");
		wr(8'h06, 8, 32'h01);
		rdc(8'h46, 8, 32'h00, "flag cleared");
		tend("reset");
		close_out();
	end
endmodule // testbench
